// *** include/exec_consts.svh ***
// Purpose: Shared constants for the instruction execution slice.
// Assumes: Included by its bare name from the design files.
// Notes: Definitions only; no logic lives here.
`ifndef EXEC_CONSTS_SVH
`define EXEC_CONSTS_SVH

// Datapath and operand widths.
`define EXEC_DATA_W 8
`define EXEC_ADDR_W 7
`define EXEC_JUMP_W 11
`define EXEC_PC_W 15
`define EXEC_LATCH_W 7

// Slice of pc_high_latch that fills the upper program counter bits.
`define EXEC_LATCH_HI 6
`define EXEC_LATCH_LO 3

// Destination select encoding.
`define EXEC_DEST_ACCUM 1'b0
`define EXEC_DEST_FILE 1'b1

// Reset values.
`define EXEC_RST_ACCUM 8'h00
`define EXEC_RST_ZERO 1'b0
`define EXEC_RST_PC 15'h0000
`define EXEC_RST_ADDR 7'h00

// Increment and decrement step.
`define EXEC_STEP 8'h01

`endif

// *** include/exec_pkg.sv ***
// Purpose: Types shared by the execution slice and its arithmetic unit.
// Assumes: The fetch and decode path presents one of these operation codes.
// Notes: Operation codes are internal; no instruction word encoding is implied.
package exec_pkg;

	// Predecoded operation presented with an issue strobe.
	typedef enum logic [2:0]
	{
		OP_NONE,
		OP_DEC_SKIP,
		OP_JUMP,
		OP_INC,
		OP_INC_SKIP,
		OP_OR_LIT,
		OP_OR_FILE
	} op_type;

	// Execution sequencer states.
	typedef enum logic
	{
		ST_IDLE,
		ST_SECOND
	} state_type;

endpackage

// *** rtl/core_incdec_skip_or_jump_absolute_exec.sv ***
// Purpose: Executes decrement/increment with skip, increment, OR and absolute jump.
// Assumes: Register file read data for file_addr_i is valid in the issue cycle.
// Notes: The accumulator and zero flag live here; file writes leave as a pulse.
`timescale 1ns/1ps
`include "exec_consts.svh"

// Notes on behaviour
// - decrement_skip_zero subtracts one from the addressed file register (address 0 to 127) into the chosen destination.
// - a zero decrement result discards the next instruction for a no-operation, making two cycles.
// - dest_select 0 writes the result to the accumulator and 1 writes it back to the file register.
// - jump_absolute loads its 11-bit operand into program counter bits 10 to 0.
// - jump_absolute fills program counter bits 14 to 11 from pc_high_latch bits 6 to 3.
// - jump_absolute always takes two cycles and changes no status flag.
// - increment_file adds one to the file register, stores per dest_select and updates zero_flag.
// - increment_skip_zero adds one, stores per dest_select, touches no flag and skips on zero.
// - or_literal_accum ORs the accumulator with an 8-bit literal into the accumulator and updates zero_flag.
// - or_accum_file ORs the accumulator with the file register, stores per dest_select and updates zero_flag.
module core_incdec_skip_or_jump_absolute_exec
#(
	parameter int DATA_W = `EXEC_DATA_W,
	parameter int ADDR_W = `EXEC_ADDR_W
)
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic issue_i,
	input wire exec_pkg::op_type op_i,
	input wire logic [ADDR_W-1:0] file_addr_i,
	input wire logic dest_select_i,
	input wire logic [`EXEC_JUMP_W-1:0] operand_i,
	input wire logic [DATA_W-1:0] file_rdata_i,
	input wire logic [`EXEC_LATCH_W-1:0] pc_high_latch_i,
	output logic [DATA_W-1:0] accum_o,
	output logic zero_flag_o,
	output logic file_we_o,
	output logic [ADDR_W-1:0] file_waddr_o,
	output logic [DATA_W-1:0] file_wdata_o,
	output logic pc_load_o,
	output logic [`EXEC_PC_W-1:0] pc_target_o,
	output logic skip_o,
	output logic busy_o,
	output logic done_o
);

	// The constants fix an 8-bit datapath and 7-bit file addresses.
	// Other widths are refused at elaboration, since the jump and latch slices assume them.
	if (DATA_W != `EXEC_DATA_W)
	begin
		$error("core_incdec_skip_or_jump_absolute_exec: DATA_W must equal 8");
	end
	if (ADDR_W != `EXEC_ADDR_W)
	begin
		$error("core_incdec_skip_or_jump_absolute_exec: ADDR_W must equal 7");
	end

	exec_pkg::state_type state_q;
	exec_pkg::state_type state_d;
	logic [DATA_W-1:0] accum_q;
	logic [DATA_W-1:0] accum_d;
	logic zero_q;
	logic zero_d;
	logic file_we_q;
	logic file_we_d;
	logic [ADDR_W-1:0] file_waddr_q;
	logic [ADDR_W-1:0] file_waddr_d;
	logic [DATA_W-1:0] file_wdata_q;
	logic [DATA_W-1:0] file_wdata_d;
	logic pc_load_q;
	logic pc_load_d;
	logic [`EXEC_PC_W-1:0] pc_target_q;
	logic [`EXEC_PC_W-1:0] pc_target_d;
	logic skip_q;
	logic skip_d;
	logic busy_q;
	logic busy_d;
	logic done_q;
	logic done_d;

	logic [DATA_W-1:0] alu_result;
	logic alu_zero;
	logic alu_skip;
	logic alu_writes_zero;
	logic alu_uses_dest;
	logic take;

	// The literal only uses the low operand bits; the jump uses all eleven.
	exec_alu
	#(
		.DATA_W(DATA_W)
	)
	u_alu
	(
		.op_i(op_i),
		.accum_i(accum_q),
		.file_i(file_rdata_i),
		.literal_i(operand_i[DATA_W-1:0]),
		.result_o(alu_result),
		.zero_o(alu_zero),
		.skip_o(alu_skip),
		.writes_zero_o(alu_writes_zero),
		.uses_dest_o(alu_uses_dest)
	);

	// An issue is taken only while idle; during a second cycle it is ignored.
	assign take = issue_i && (state_q == exec_pkg::ST_IDLE) && (op_i != exec_pkg::OP_NONE);

	// Next-state and result logic for the whole slice.
	always_comb
	begin
		state_d = state_q;
		accum_d = accum_q;
		zero_d = zero_q;
		file_we_d = 1'b0;
		file_waddr_d = file_waddr_q;
		file_wdata_d = file_wdata_q;
		pc_load_d = 1'b0;
		pc_target_d = pc_target_q;
		skip_d = 1'b0;
		busy_d = 1'b0;
		done_d = 1'b0;
		case (state_q)
			exec_pkg::ST_IDLE:
			begin
				if (take)
				begin
					if (op_i == exec_pkg::OP_JUMP)
					begin
						// The flags are left alone on a jump.
						pc_target_d[`EXEC_JUMP_W-1:0] = operand_i;
						pc_target_d[`EXEC_PC_W-1:`EXEC_JUMP_W] =
							pc_high_latch_i[`EXEC_LATCH_HI:`EXEC_LATCH_LO];
						pc_load_d = 1'b1;
						busy_d = 1'b1;
						state_d = exec_pkg::ST_SECOND;
					end
					else
					begin
						if (alu_uses_dest && (dest_select_i == `EXEC_DEST_FILE))
						begin
							file_we_d = 1'b1;
							file_waddr_d = file_addr_i;
							file_wdata_d = alu_result;
						end
						else
						begin
							accum_d = alu_result;
						end
						if (alu_writes_zero)
							zero_d = alu_zero;
						if (alu_skip)
						begin
							// The fetch path squashes the next word into a no-operation.
							skip_d = 1'b1;
							busy_d = 1'b1;
							state_d = exec_pkg::ST_SECOND;
						end
						else
						begin
							done_d = 1'b1;
						end
					end
				end
			end
			exec_pkg::ST_SECOND:
			begin
				// The second cycle is the discarded slot; nothing is written.
				done_d = 1'b1;
				state_d = exec_pkg::ST_IDLE;
			end
			default:
			begin
				state_d = exec_pkg::ST_IDLE;
			end
		endcase
	end

	// Register stage; every output comes straight from these flops.
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			state_q <= exec_pkg::ST_IDLE;
			accum_q <= `EXEC_RST_ACCUM;
			zero_q <= `EXEC_RST_ZERO;
			file_we_q <= 1'b0;
			file_waddr_q <= `EXEC_RST_ADDR;
			file_wdata_q <= `EXEC_RST_ACCUM;
			pc_load_q <= 1'b0;
			pc_target_q <= `EXEC_RST_PC;
			skip_q <= 1'b0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			accum_q <= accum_d;
			zero_q <= zero_d;
			file_we_q <= file_we_d;
			file_waddr_q <= file_waddr_d;
			file_wdata_q <= file_wdata_d;
			pc_load_q <= pc_load_d;
			pc_target_q <= pc_target_d;
			skip_q <= skip_d;
			busy_q <= busy_d;
			done_q <= done_d;
		end
	end

	// Output connections.
	assign accum_o = accum_q;
	assign zero_flag_o = zero_q;
	assign file_we_o = file_we_q;
	assign file_waddr_o = file_waddr_q;
	assign file_wdata_o = file_wdata_q;
	assign pc_load_o = pc_load_q;
	assign pc_target_o = pc_target_q;
	assign skip_o = skip_q;
	assign busy_o = busy_q;
	assign done_o = done_q;

endmodule

// *** rtl/exec_alu.sv ***
// Purpose: Combinational result, zero test and skip decision for the slice.
// Assumes: Operands are stable in the issue cycle.
// Notes: Wraps modulo 2**DATA_W, so 8'hFF plus one gives zero and, for OP_INC_SKIP, skips.
`timescale 1ns/1ps
`include "exec_consts.svh"

module exec_alu
#(
	parameter int DATA_W = `EXEC_DATA_W
)
(
	input wire exec_pkg::op_type op_i,
	input wire logic [DATA_W-1:0] accum_i,
	input wire logic [DATA_W-1:0] file_i,
	input wire logic [DATA_W-1:0] literal_i,
	output logic [DATA_W-1:0] result_o,
	output logic zero_o,
	output logic skip_o,
	output logic writes_zero_o,
	output logic uses_dest_o
);

	// A one-bit datapath cannot tell zero from an increment, so refuse it at elaboration.
	if (DATA_W < 2)
	begin
		$error("exec_alu: DATA_W must be at least 2");
	end

	// Select the operation result and its flag and skip effects.
	always_comb
	begin
		result_o = '0;
		writes_zero_o = 1'b0;
		uses_dest_o = 1'b0;
		skip_o = 1'b0;
		case (op_i)
			exec_pkg::OP_DEC_SKIP:
			begin
				result_o = DATA_W'(file_i - DATA_W'(`EXEC_STEP));
				uses_dest_o = 1'b1;
				skip_o = (result_o == '0);
			end
			exec_pkg::OP_INC:
			begin
				result_o = DATA_W'(file_i + DATA_W'(`EXEC_STEP));
				uses_dest_o = 1'b1;
				writes_zero_o = 1'b1;
			end
			exec_pkg::OP_INC_SKIP:
			begin
				result_o = DATA_W'(file_i + DATA_W'(`EXEC_STEP));
				uses_dest_o = 1'b1;
				skip_o = (result_o == '0);
			end
			exec_pkg::OP_OR_LIT:
			begin
				result_o = accum_i | literal_i;
				writes_zero_o = 1'b1;
			end
			exec_pkg::OP_OR_FILE:
			begin
				result_o = accum_i | file_i;
				uses_dest_o = 1'b1;
				writes_zero_o = 1'b1;
			end
			default:
			begin
				result_o = '0;
			end
		endcase
		zero_o = (result_o == '0);
	end

endmodule

// *** testbench/exec_chk.sv ***
// Purpose: Port assertions for the execution slice.
// Assumes: Op codes follow the package enum order.
// Notes: res_q and tgt_q hold what the op offered in the previous cycle must produce.
`timescale 1ns/1ps
module exec_chk
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic issue_i,
	input wire exec_pkg::op_type op_i,
	input wire logic [6:0] file_addr_i,
	input wire logic dest_select_i,
	input wire logic [10:0] operand_i,
	input wire logic [7:0] file_rdata_i,
	input wire logic [6:0] pc_high_latch_i,
	input wire logic [7:0] accum_o,
	input wire logic zero_flag_o,
	input wire logic file_we_o,
	input wire logic [6:0] file_waddr_o,
	input wire logic [7:0] file_wdata_o,
	input wire logic pc_load_o,
	input wire logic [14:0] pc_target_o,
	input wire logic skip_o,
	input wire logic busy_o,
	input wire logic done_o
);
default clocking @(posedge core_clk_i); endclocking
default disable iff (rst_i);
logic [7:0] res_d, res_q;
logic [14:0] tgt_q;
wire [2:0] o = op_i;
wire tk = issue_i && o != 3'h0 && !busy_o;
wire sk = o == 3'h1 || o == 3'h4;
wire sg = o == 3'h3 || o > 3'h4;
wire fw = dest_select_i && o != 3'h2 && o != 3'h5;

// Result of the op now offered; the wrap at 8 bits is what makes FF plus one skip.
always_comb
begin
	case (o)
		3'h1: res_d = file_rdata_i - 8'h01;
		3'h3, 3'h4: res_d = file_rdata_i + 8'h01;
		3'h5: res_d = accum_o | operand_i[7:0];
		default: res_d = accum_o | file_rdata_i;
	endcase
end

// Kept one cycle so the outputs can be compared when they appear.
always_ff @(posedge core_clk_i)
begin
	res_q <= res_d;
	tgt_q <= {pc_high_latch_i[6:3], operand_i};
end

a_jump_load: assert property (tk && o == 3'h2 |=> pc_load_o && pc_target_o == tgt_q)
	else $error("jump target wrong");
a_jump_two: assert property (tk && o == 3'h2 |=> busy_o ##1 done_o && !busy_o)
	else $error("jump length wrong");
a_flag_keep: assert property (tk && (sk || o == 3'h2) |=> $stable(zero_flag_o))
	else $error("zero flag moved");
a_single_op: assert property (tk && sg |=> done_o && !busy_o && !pc_load_o)
	else $error("single op not done");
a_skip_zero: assert property (tk && sk |=> skip_o == (res_q == 8'h00) && busy_o == skip_o)
	else $error("skip decision wrong");
a_skip_done: assert property (tk && sk ##1 skip_o |=> done_o)
	else $error("skip not done");
a_flag_value: assert property (tk && sg |=> zero_flag_o == (res_q == 8'h00))
	else $error("zero flag wrong");
a_dest_file: assert property (tk && fw |=> file_we_o && file_wdata_o == res_q && file_waddr_o == $past(file_addr_i))
	else $error("file write wrong");
a_dest_accum: assert property (tk && o != 3'h2 && !fw |=> !file_we_o && accum_o == res_q)
	else $error("accumulator wrong");
c_jump: cover property (tk && o == 3'h2);
c_skip: cover property (skip_o);
c_write: cover property (file_we_o && done_o);
endmodule

// *** testbench/tb_core_incdec_skip_or_jump_absolute_exec.sv ***
// Purpose: Self-checking bench for the execution slice.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes: An integer model predicts every result.
`timescale 1ns/1ps
module tb_core_incdec_skip_or_jump_absolute_exec;
logic core_clk_i = 0, rst_i = 1, issue_i = 0, dest_select_i = 0;
exec_pkg::op_type op_i = exec_pkg::OP_NONE;
logic [6:0] file_addr_i = 0, pc_high_latch_i = 0, file_waddr_o;
logic [10:0] operand_i = 0;
logic [7:0] file_rdata_i = 0, accum_o, file_wdata_o;
logic zero_flag_o, file_we_o, pc_load_o, skip_o, busy_o, done_o;
logic [14:0] pc_target_o;
logic [31:0] rnd = 32'hC932;
int n_mismatch = 0, checks_done = 0, acc = 0, z = 0;

core_incdec_skip_or_jump_absolute_exec i_dut (.core_clk_i, .rst_i, .issue_i, .op_i, .file_addr_i, .dest_select_i,
	.operand_i, .file_rdata_i, .pc_high_latch_i, .accum_o, .zero_flag_o, .file_we_o, .file_waddr_o,
	.file_wdata_o, .pc_load_o, .pc_target_o, .skip_o, .busy_o, .done_o);

// Free-running clock at 100 MHz.
always #5 core_clk_i = ~core_clk_i;

// Compares one result and counts it.
task chk(input logic [15:0] g, input logic [15:0] e);
	checks_done++;
	if (g !== e)
		$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
	if (g !== e)
		n_mismatch++;
endtask

function automatic logic [31:0] xs();
	rnd ^= rnd << 13;
	rnd ^= rnd >> 17;
	rnd ^= rnd << 5;
	return rnd;
endfunction

// Issues one op and checks it; issue stays high so single ops run back to back.
task run(input int o, input logic [7:0] fd, input logic d);
	int r;
	logic [31:0] v;
	logic sk, w, e;
	v = xs();
	op_i = exec_pkg::op_type'(o);
	file_rdata_i = fd;
	dest_select_i = d;
	operand_i = o == 5 ? {v[10:8], fd} : v[10:0];
	file_addr_i = v[17:11];
	pc_high_latch_i = v[24:18];
	issue_i = 1;
	r = o == 1 ? (fd - 1) & 255 : (o == 3 || o == 4) ? (fd + 1) & 255 : acc | fd;
	@(posedge core_clk_i);
	#1;
	sk = (o == 1 || o == 4) && r == 0;
	e = o != 0 && o != 2;
	w = d && e && o != 5;
	chk({skip_o, pc_load_o, busy_o, done_o}, {sk, o == 2, sk || o == 2, e && !sk});
	chk(file_we_o, w);
	if (w) chk({file_waddr_o, file_wdata_o}, {file_addr_i, r[7:0]});
	else if (e) acc = r;
	if (o == 3 || o > 4) z = r == 0;
	chk({zero_flag_o, accum_o}, {z[0], acc[7:0]});
	if (o == 2) chk(pc_target_o, {pc_high_latch_i[6:3], operand_i});
	// An op offered in the busy cycle must be ignored.
	if (sk || o == 2)
	begin
		op_i = exec_pkg::OP_INC;
		@(posedge core_clk_i);
		#1;
		chk({done_o, file_we_o, busy_o, accum_o}, {3'b100, acc[7:0]});
	end
endtask

task summarize();
	$display("checks %0d mismatches %0d", checks_done, n_mismatch);
	if (n_mismatch == 0 && checks_done > 0)
		$display("Regression OK");
	else
		$display("Regression broken");
	$finish;
endtask

// Directed edge cases first, then random ops from the xorshift source.
initial
begin
	repeat (5) @(posedge core_clk_i);
	#1;
	rst_i = 0;
	@(posedge core_clk_i);
	#1;
	run(5, 8'h00, 0);
	run(2, 8'h00, 1);
	run(1, 8'h01, 0);
	run(4, 8'hFF, 1);
	run(3, 8'hFF, 0);
	run(0, 8'h3C, 1);
	run(6, 8'h00, 1);
	$display("test directed done");
	repeat (80) run(xs() % 7, rnd[15:8], rnd[16]);
	$display("test random done");
	// A reset in mid-run must clear every register; issue stays low through the release edge.
	issue_i = 0;
	rst_i = 1;
	@(posedge core_clk_i);
	#1;
	rst_i = 0;
	acc = 0;
	z = 0;
	chk({accum_o, zero_flag_o, file_we_o, pc_load_o, skip_o, busy_o, done_o}, 16'h0000);
	chk({file_waddr_o, file_wdata_o}, 16'h0000);
	chk(pc_target_o, 16'h0000);
	@(posedge core_clk_i);
	#1;
	run(6, 8'h5A, 0);
	run(5, 8'h00, 1);
	$display("test reset done");
	issue_i = 0;
	@(posedge core_clk_i);
	summarize();
end

// Cuts a hang short at 2000 cycles, well beyond the fewer than 200 cycles the tests need.
initial
begin
	#20000;
	n_mismatch++;
	summarize();
end
endmodule

bind core_incdec_skip_or_jump_absolute_exec exec_chk i_chk (.core_clk_i, .rst_i, .issue_i, .op_i, .file_addr_i,
	.dest_select_i, .operand_i, .file_rdata_i, .pc_high_latch_i, .accum_o, .zero_flag_o, .file_we_o,
	.file_waddr_o, .file_wdata_o, .pc_load_o, .pc_target_o, .skip_o, .busy_o, .done_o);
